/* File: pacs_defs.svh */
// Constants of the auxiliary control and status register block.
// Assumes inclusion by its bare name from the package and the modules.
`ifndef PACS_DEFS_SVH
`define PACS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define PACS_AUX_CS_OFFSET   8'h1C
`define PACS_ADDR_W          8
`define PACS_RESP_OKAY       2'h0
`define PACS_RESP_SLVERR     2'h2

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PACS_BIT_AN_DONE     15
`define PACS_BIT_AN_OFF      14
`define PACS_BIT_XOVER       13
`define PACS_BIT_CD_SWAP     12
`define PACS_BIT_POL_HI      11
`define PACS_BIT_POL_LO      8
`define PACS_BIT_TMO_HI      7
`define PACS_BIT_PS_EN       6
`define PACS_BIT_FDX         5
`define PACS_BIT_SPD_HI      4
`define PACS_BIT_SPD_LO      3
`define PACS_BIT_TMO_LO      2
`define PACS_BIT_MED_HI      1
`define PACS_BIT_MED_LO      0

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define PACS_TMO_HI_RST      1'h0
`define PACS_TMO_LO_RST      1'h1
`define PACS_PS_EN_RST       1'h0
`define PACS_TMO_MS_00       2300
`define PACS_TMO_MS_01       3300
`define PACS_TMO_MS_10       4300
`define PACS_TMO_MS_11       5300
`define PACS_SPD_10          2'h0
`define PACS_SPD_100         2'h1
`define PACS_SPD_1000        2'h2
`define PACS_MED_NONE        2'h0
`define PACS_MED_COPPER      2'h1
`define PACS_MED_FIBER       2'h2

`endif

/* File: pacs_pkg.sv */
// Types of the auxiliary control and status register block.
// Assumes pacs_defs.svh is on the include path.
`include "pacs_defs.svh"

package pacs_pkg;

  // --------------------------------------------------------------------------
  // Status gathered from the PHY cores
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       an_enable;
    logic       an_complete;
    logic       link_up;
    logic       automatic_media_sense;
    logic       fiber_100_sel;
    logic       xover_done;
    logic       cd_swap;
    logic [3:0] pol_inv;
    logic       full_duplex_flag;
    logic [1:0] speed;
    logic [1:0] media;
    logic       gigabit_copper_mode;
    logic       renegotiate;
  } pacs_status_t;

  // --------------------------------------------------------------------------
  // Sticky controls
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] tmo_sel;
    logic       ps_en;
  } pacs_ctrl_t;

  typedef enum logic [2:0] {
    PACS_R_IDLE = 3'b001,
    PACS_R_DATA = 3'b010,
    PACS_R_WAIT = 3'b100
  } pacs_rd_state_t;

endpackage : pacs_pkg

/* File: pacs_xover_hold.sv */
// Holds the crossover indication stable while a gigabit copper link is up and no renegotiation is signalled.
// Assumes synchronous status inputs and a synchronised active-low reset.
`include "pacs_defs.svh"

module pacs_xover_hold
  import pacs_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_sync_b,
  // Status
  input  wire logic xover_raw,
  input  wire logic link_up,
  input  wire logic gigabit_copper_mode,
  input  wire logic renegotiate,
  // Indication
  output logic      xover_ind
);

  // --------------------------------------------------------------------------
  // Freeze control
  // --------------------------------------------------------------------------
  // While frozen the latched value stands until the link renegotiates, goes down or leaves gigabit copper mode.
  wire frozen = link_up & gigabit_copper_mode & ~renegotiate;
  wire next_xover_ind = frozen ? xover_ind : xover_raw;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      xover_ind <= 1'b0;
    end else begin
      xover_ind <= next_xover_ind;
    end
  end

  frozen_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    $past(frozen) |-> xover_ind == $past(xover_ind))
    else $error("Crossover indication changed while frozen.");

  free_track_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    !frozen |=> xover_ind == $past(xover_raw))
    else $error("Crossover indication did not track.");

endmodule // pacs_xover_hold

/* File: pacs_aux_cs.sv */
// Auxiliary control and status register, reached over AXI4-Lite.
// Assumes status inputs are synchronous to clk and held by the PHY cores.
`include "pacs_defs.svh"

module pacs_aux_cs
  import pacs_pkg::*;
#(
  parameter int ADDR_W = `PACS_ADDR_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // PHY status
  input  wire pacs_status_t      status,
  // Controls to the power saving logic
  output logic                   ps_enable,
  output logic [1:0]             ps_timeout_sel
);

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must be 5 to 32.");
  end

  // --------------------------------------------------------------------------
  // Reset synchroniser
  // --------------------------------------------------------------------------
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // Register byte address at the bus width; only the word index is compared.
  localparam logic [ADDR_W-1:0] REG_ADDR = ADDR_W'(`PACS_AUX_CS_OFFSET);

  function automatic logic hits_reg(input logic [ADDR_W-1:0] a);
    hits_reg = (a[ADDR_W-1:2] == REG_ADDR[ADDR_W-1:2]);
  endfunction

  // --------------------------------------------------------------------------
  // Status composition
  // --------------------------------------------------------------------------
  pacs_ctrl_t ctrl;
  logic       xover_ind;

  pacs_xover_hold u_xover_hold (
    .clk                 (clk),
    .rst_sync_b          (rst_sync_b),
    .xover_raw           (status.xover_done),
    .link_up             (status.link_up),
    .gigabit_copper_mode (status.gigabit_copper_mode),
    .renegotiate         (status.renegotiate),
    .xover_ind           (xover_ind)
  );

  wire       an_done_bit = status.an_enable ? status.an_complete : status.link_up;
  wire       an_off_bit  = ~status.an_enable |
                           (status.automatic_media_sense & status.fiber_100_sel);
  wire [15:0] reg_value  = {an_done_bit,
                            an_off_bit,
                            xover_ind,
                            status.cd_swap,
                            status.pol_inv,
                            ctrl.tmo_sel[1],
                            ctrl.ps_en,
                            status.full_duplex_flag,
                            status.speed,
                            ctrl.tmo_sel[0],
                            status.media};

  // --------------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------------
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire wr_fire  = aw_held & w_held & ~s_axi_bvalid;
  wire wr_hit   = hits_reg(aw_addr);
  wire wr_lo    = wr_fire & wr_hit & w_strb[0];

  pacs_ctrl_t next_ctrl;
  assign next_ctrl.tmo_sel = wr_lo ? {w_data[`PACS_BIT_TMO_HI], w_data[`PACS_BIT_TMO_LO]}
                                   : ctrl.tmo_sel;
  assign next_ctrl.ps_en   = wr_lo ? w_data[`PACS_BIT_PS_EN] : ctrl.ps_en;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl <= '{tmo_sel: {`PACS_TMO_HI_RST, `PACS_TMO_LO_RST}, ps_en: `PACS_PS_EN_RST};
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PACS_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `PACS_RESP_OKAY : `PACS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  pacs_rd_state_t rd_state;
  pacs_rd_state_t next_rd_state;

  wire ar_take = s_axi_arvalid & s_axi_arready;

  // The wait state leaves one quiet cycle after each read answer before arready rises again.
  always_comb begin
    case (rd_state)
      PACS_R_IDLE: next_rd_state = ar_take ? PACS_R_DATA : PACS_R_IDLE;
      PACS_R_DATA: next_rd_state = (s_axi_rvalid & s_axi_rready) ? PACS_R_WAIT : PACS_R_DATA;
      PACS_R_WAIT: next_rd_state = PACS_R_IDLE;
      default:     next_rd_state = PACS_R_IDLE;
    endcase
  end

  // Reads only sample the register value; nothing is cleared by them.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rd_state      <= PACS_R_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `PACS_RESP_OKAY;
    end else begin
      rd_state      <= next_rd_state;
      s_axi_arready <= (next_rd_state == PACS_R_IDLE) & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= hits_reg(s_axi_araddr) ? {16'h0000, reg_value} : 32'h0000_0000;
        s_axi_rresp  <= hits_reg(s_axi_araddr) ? `PACS_RESP_OKAY : `PACS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ps_enable      <= `PACS_PS_EN_RST;
      ps_timeout_sel <= {`PACS_TMO_HI_RST, `PACS_TMO_LO_RST};
    end else begin
      ps_enable      <= next_ctrl.ps_en;
      ps_timeout_sel <= next_ctrl.tmo_sel;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  an_done_read_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    ar_take && hits_reg(s_axi_araddr) |=>
      s_axi_rdata[15] == ($past(status.an_enable) ? $past(status.an_complete) : $past(status.link_up)))
    else $error("Bit 15 read wrong.");

  an_off_read_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    ar_take && hits_reg(s_axi_araddr) && !status.an_enable |=> s_axi_rdata[14])
    else $error("Bit 14 not set with autonegotiation off.");

  status_read_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    ar_take && hits_reg(s_axi_araddr) |=>
      s_axi_rdata[12:8] == {$past(status.cd_swap), $past(status.pol_inv)})
    else $error("Pair status read wrong.");

  speed_media_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    ar_take && hits_reg(s_axi_araddr) |=>
      s_axi_rdata[4:0] == {$past(status.speed), $past(ctrl.tmo_sel[0]), $past(status.media)})
    else $error("Speed or media read wrong.");

  tmo_write_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    wr_lo |=> ps_timeout_sel == {$past(w_data[7]), $past(w_data[2])} && s_axi_bvalid)
    else $error("Timeout write not applied.");

  tmo_reset_a: assert property (@(posedge clk)
    $rose(rst_sync_b) |-> ps_timeout_sel == 2'h1 && !ps_enable)
    else $error("Control reset value wrong.");

  ctrl_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    !wr_lo |=> ps_enable == $past(ps_enable) && ps_timeout_sel == $past(ps_timeout_sel))
    else $error("Control changed without a write.");

  read_answer_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    ar_take |=> s_axi_rvalid)
    else $error("Read not answered next cycle.");

  write_answer_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    wr_fire |=> s_axi_bvalid)
    else $error("Write not answered next cycle.");

  xover_read_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    ar_take && hits_reg(s_axi_araddr) |=> s_axi_rdata[13] == $past(xover_ind))
    else $error("Bit 13 read wrong.");

  cd_swap_read_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    ar_take && hits_reg(s_axi_araddr) |=> s_axi_rdata[12] == $past(status.cd_swap))
    else $error("Bit 12 read wrong.");

  media_read_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    ar_take && hits_reg(s_axi_araddr) |=> s_axi_rdata[1:0] == $past(status.media))
    else $error("Media bits read wrong.");

  duplex_read_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    ar_take && hits_reg(s_axi_araddr) |=> s_axi_rdata[6:5] == {$past(ctrl.ps_en), $past(status.full_duplex_flag)})
    else $error("Bits 6 and 5 read wrong.");

  tmo_read_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    ar_take && hits_reg(s_axi_araddr) |=> {s_axi_rdata[7], s_axi_rdata[2]} == $past(ctrl.tmo_sel))
    else $error("Timeout bits read wrong.");

  upper_zero_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    ar_take |=> s_axi_rdata[31:16] == 16'h0000)
    else $error("Upper read half not zero.");

  ar_refuse_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address accepted while a read is open.");

  wr_refuse_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write accepted while a response is open.");

  cov_write_c: cover property (@(posedge clk) disable iff (!rst_sync_b) wr_lo);
  cov_read_c: cover property (@(posedge clk) disable iff (!rst_sync_b) ar_take ##1 s_axi_rvalid);
  cov_unmapped_c: cover property (@(posedge clk) disable iff (!rst_sync_b)
    s_axi_bvalid && s_axi_bresp == `PACS_RESP_SLVERR);
  cov_freeze_c: cover property (@(posedge clk) disable iff (!rst_sync_b)
    status.link_up && status.gigabit_copper_mode && $changed(status.xover_done));

endmodule // pacs_aux_cs

/* File: tb_top.sv */
// Self-checking bench for the auxiliary control and status register block.
// Assumes pacs_pkg is compiled first and pacs_defs.svh is on the include path.
`include "pacs_defs.svh"

module tb_top
  import pacs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic         clk;
  logic         rst_b;
  logic         s_axi_awvalid;
  logic         s_axi_awready;
  logic [7:0]   s_axi_awaddr;
  logic         s_axi_wvalid;
  logic         s_axi_wready;
  logic [31:0]  s_axi_wdata;
  logic [3:0]   s_axi_wstrb;
  logic         s_axi_bvalid;
  logic         s_axi_bready;
  logic [1:0]   s_axi_bresp;
  logic         s_axi_arvalid;
  logic         s_axi_arready;
  logic [7:0]   s_axi_araddr;
  logic         s_axi_rvalid;
  logic         s_axi_rready;
  logic [31:0]  s_axi_rdata;
  logic [1:0]   s_axi_rresp;
  pacs_status_t status;
  logic         ps_enable;
  logic [1:0]   ps_timeout_sel;
  int           err_count;
  int           comparisons;

  pacs_aux_cs i_dut (
    .clk(clk), .rst_b(rst_b),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .status(status),
    .ps_enable(ps_enable), .ps_timeout_sel(ps_timeout_sel)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic stop_test();
    $display("Checks made: %0d, mismatches: %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  task automatic hang(input string name);
    $display("MISMATCH %s expected response seen none", name);
    err_count++;
    stop_test();
  endtask

  // Offers address and data together and holds bready until the response.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int   n;
    logic aw_done;
    logic w_done;
    logic got;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    got = 1'b0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'b1;
    while (!got && n < 100) begin
      @(posedge clk);
      n++;
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        got = 1'b1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (!got) hang("write response");
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    while (!got && n < 100) begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        got = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!got) hang("read response");
  endtask

  // Drives the status levels and lets them settle for three cycles.
  task automatic set_st(input pacs_status_t st);
    @(posedge clk);
    status <= st;
    repeat (3) @(posedge clk);
  endtask

  // Expected register word built field by field.
  function automatic logic [15:0] exp_word(pacs_status_t st, logic x, logic [1:0] tmo, logic ps);
    exp_word = {st.an_enable ? st.an_complete : st.link_up,
                ~st.an_enable | (st.automatic_media_sense & st.fiber_100_sel),
                x, st.cd_swap, st.pol_inv, tmo[1], ps, st.full_duplex_flag,
                st.speed, tmo[0], st.media};
  endfunction

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    chk({name, " data"}, exp, d);
    chk({name, " resp"}, {30'h0, er}, {30'h0, r});
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    pacs_status_t st;
    logic [1:0]   r;
    logic [1:0]   c;
    err_count = 0;
    comparisons = 0;
    rst_b = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_rready = 1'b0;
    status = '0;
    st = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk("timeout sel reset", 32'h1, {30'h0, ps_timeout_sel});
    chk("ps enable reset", 32'h0, {31'h0, ps_enable});
    rd_chk("reset word", `PACS_AUX_CS_OFFSET, {16'h0, exp_word(st, 1'b0, 2'h1, 1'b0)}, `PACS_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      st = '0;
      st.an_enable = i[0];
      st.an_complete = i[1];
      st.link_up = ~i[1];
      st.automatic_media_sense = i[2];
      st.fiber_100_sel = i[0] | i[1];
      st.xover_done = i[1];
      st.cd_swap = i[2] ^ i[0];
      st.pol_inv = (4'h1 << i[1:0]) ^ {4{i[2]}};
      st.full_duplex_flag = i[0];
      st.speed = i[1:0];
      st.media = i[2:1];
      set_st(st);
      rd_chk("status word", `PACS_AUX_CS_OFFSET, {16'h0, exp_word(st, i[1], 2'h1, 1'b0)}, `PACS_RESP_OKAY);
    end
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      axi_write(`PACS_AUX_CS_OFFSET, 32'hFFFF_FF3B | {c[1], c[0], 3'h0, c[0], 2'h0}, 4'hF, r);
      chk("write resp", 32'h0, {30'h0, r});
      chk("timeout sel", {30'h0, c}, {30'h0, ps_timeout_sel});
      chk("ps enable", {31'h0, c[0]}, {31'h0, ps_enable});
      rd_chk("written word", `PACS_AUX_CS_OFFSET, {16'h0, exp_word(st, 1'b1, c, c[0])}, `PACS_RESP_OKAY);
    end
    axi_write(`PACS_AUX_CS_OFFSET, 32'h0, 4'hE, r);
    chk("lane0 off resp", 32'h0, {30'h0, r});
    chk("lane0 off timeout", 32'h3, {30'h0, ps_timeout_sel});
    axi_write(8'h18, 32'h0, 4'hF, r);
    chk("unmapped write resp", {30'h0, `PACS_RESP_SLVERR}, {30'h0, r});
    chk("unmapped write ps", 32'h1, {31'h0, ps_enable});
    rd_chk("unmapped read", 8'h20, 32'h0, `PACS_RESP_SLVERR);
    st = '0;
    set_st(st);
    st.link_up = 1'b1;
    st.gigabit_copper_mode = 1'b1;
    set_st(st);
    st.xover_done = 1'b1;
    set_st(st);
    rd_chk("xover frozen", `PACS_AUX_CS_OFFSET, {16'h0, exp_word(st, 1'b0, 2'h3, 1'b1)}, `PACS_RESP_OKAY);
    st.renegotiate = 1'b1;
    set_st(st);
    rd_chk("xover released", `PACS_AUX_CS_OFFSET, {16'h0, exp_word(st, 1'b1, 2'h3, 1'b1)}, `PACS_RESP_OKAY);
    stop_test();
  end

endmodule // tb_top
